// file: rtl/cot_pkg.sv
// constants, register map and carrier types for the output timing block
//
// Operation
// R1 - steered output carries waveform with polarity
// R2 - unsteered output holds its static level
// R3 - steering acts only in steering modes
// R4 - rising dead-band counts clock periods
// R5 - rising dead-band may count chain elements
// R6 - falling dead-band counts clock periods
// R7 - falling dead-band may count chain elements
// R8 - rising event blanks falling events
// R9 - falling event blanks rising events
// R10 - rising event delayed by rising phase
// R11 - falling event delayed by falling phase
// R12 - count registers upper two bits read zero
// R13 - counts clear on reset, rising blanking kept
// R14 - zero count adds no delay
package cot_pkg;
  // count field width
  localparam int unsigned CNT_W = 6;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_STEER = 8'h08;
  localparam logic [7:0] OFS_DBR = 8'h0c;
  localparam logic [7:0] OFS_DBF = 8'h10;
  localparam logic [7:0] OFS_BLKR = 8'h14;
  localparam logic [7:0] OFS_BLKF = 8'h18;
  localparam logic [7:0] OFS_PHR = 8'h1c;
  localparam logic [7:0] OFS_PHF = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // field positions
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned RISING_DEADBAND_SOURCE_SEL_BIT = 7;
  localparam int unsigned FALLING_DEADBAND_SOURCE_SEL_BIT = 6;
  localparam int unsigned POL_LSB = 1;
  localparam int unsigned STR_LSB = 1;
  localparam int unsigned SDAT_LSB = 5;
  // mode field upper bits that select the steering modes
  localparam logic [1:0] STEER_MODE_HI = 2'h0;
  // values after reset
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [2:0] RST_BITS3 = 3'h0;
  localparam logic [CNT_W-1:0] RST_COUNT = 6'h00;
  localparam logic [CNT_W-1:0] RST_BLKR_POR = 6'h00;
  // register write carrier from the bus slave
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
  } cot_regwr_t;
endpackage : cot_pkg

// file: rtl/cot_delay.sv
// one-shot down counter for phase, dead-band and blanking intervals
`timescale 1ns/1ps
`default_nettype none
module cot_delay #(
  parameter int unsigned W = 6
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clear,
  // count control
  input wire logic tick,
  input wire logic start,
  input wire logic [W-1:0] count,
  // results
  output logic done,
  output logic busy
);
  logic [W-1:0] remain;

  // zero count finishes in the start cycle itself
  assign busy = remain != '0;
  // R14 zero count done at once
  assign done = (start && count == '0) || (!start && tick && remain == W'(1));

  // a new start reloads, so a retrigger restarts the interval
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      remain <= '0;
    end else if (clear) begin
      remain <= '0;
    end else if (start) begin
      remain <= count;
    end else if (tick && busy) begin
      remain <= remain - W'(1);
    end
  end
endmodule : cot_delay
`default_nettype wire

// file: rtl/cot_ahb_slave.sv
// zero-wait AHB-Lite slave front end for the register file
`timescale 1ns/1ps
`default_nettype none
module cot_ahb_slave (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // register file side
  output cot_pkg::cot_regwr_t regWr,
  output logic [7:0] rdAddr,
  input wire logic [31:0] rdData
);
  import cot_pkg::*;
  logic dphWrite;
  logic dphRead;
  logic [7:0] dphAddr;
  logic take;

  // word transfers to the low page only; others read zero, writes dropped
  assign take = hsel && hready && htrans[1] && hsize == 3'h2 && haddr[31:8] == 24'h000000;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dphWrite <= 1'b0;
      dphRead <= 1'b0;
      dphAddr <= 8'h00;
    end else if (hready) begin
      dphWrite <= take && hwrite;
      dphRead <= take && !hwrite;
      dphAddr <= haddr[7:0];
    end
  end

  // data phase
  assign regWr.en = dphWrite;
  assign regWr.addr = dphAddr;
  assign regWr.data = hwdata;
  assign rdAddr = dphAddr;
  assign hrdata = dphRead ? rdData : 32'h00000000;
endmodule : cot_ahb_slave
`default_nettype wire

// file: rtl/cot_output_timing.sv
// phase, dead-band, blanking and steering for the complementary outputs
`timescale 1ns/1ps
`default_nettype none
module cot_output_timing #(
  parameter int unsigned CHAIN_DIV = 2
) (
  // clock and resets
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sysReset,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // event inputs
  input wire logic riseEvent,
  input wire logic fallEvent,
  // output pins
  output logic outB,
  output logic outC,
  output logic outD
);
  import cot_pkg::*;

  localparam int DW = (CHAIN_DIV > 1) ? $clog2(CHAIN_DIV) : 1;

  cot_regwr_t regWr;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  logic [2:0] generator_mode_field;
  logic rising_deadband_source_sel;
  logic falling_deadband_source_sel;
  logic [2:0] polarity;
  logic [2:0] steerEnable;
  logic [2:0] staticLevel;
  logic [CNT_W-1:0] rising_deadband_value;
  logic [CNT_W-1:0] falling_deadband_value;
  logic [CNT_W-1:0] rising_blanking_value;
  logic [CNT_W-1:0] falling_blanking_value;
  logic [CNT_W-1:0] rising_phase_value;
  logic [CNT_W-1:0] falling_phase_value;
  logic [DW-1:0] divCnt;
  logic chainTick;
  logic riseIgnored;
  logic fallIgnored;
  logic riseAcc;
  logic fallAcc;
  logic riseSet;
  logic fallSet;
  logic wave;
  logic primary;
  logic complement;
  logic dbRiseDone;
  logic dbFallDone;
  logic steerOn;
  logic [2:0] waveSel;
  logic [2:0] pins;
  logic [2:0] next_pins;

  // register write hit
  function automatic logic wrHit(input cot_regwr_t w, input logic [7:0] ofs);
    return w.en && w.addr == ofs;
  endfunction : wrHit

  // bus front end
  cot_ahb_slave u_bus (
    .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .regWr(regWr), .rdAddr(rdAddr), .rdData(rdData)
  );

  // control, polarity and steering registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      generator_mode_field <= RST_MODE;
      rising_deadband_source_sel <= 1'b0;
      falling_deadband_source_sel <= 1'b0;
      polarity <= RST_BITS3;
      steerEnable <= RST_BITS3;
      staticLevel <= RST_BITS3;
    end else if (sysReset) begin
      generator_mode_field <= RST_MODE;
      rising_deadband_source_sel <= 1'b0;
      falling_deadband_source_sel <= 1'b0;
      polarity <= RST_BITS3;
      steerEnable <= RST_BITS3;
      staticLevel <= RST_BITS3;
    end else begin
      if (wrHit(regWr, OFS_CTRL0)) begin
        generator_mode_field <= regWr.data[MODE_LSB +: 3];
      end
      if (wrHit(regWr, OFS_CTRL1)) begin
        rising_deadband_source_sel <= regWr.data[RISING_DEADBAND_SOURCE_SEL_BIT];
        falling_deadband_source_sel <= regWr.data[FALLING_DEADBAND_SOURCE_SEL_BIT];
        polarity <= regWr.data[POL_LSB +: 3];
      end
      if (wrHit(regWr, OFS_STEER)) begin
        steerEnable <= regWr.data[STR_LSB +: 3];
        staticLevel <= regWr.data[SDAT_LSB +: 3];
      end
    end
  end

  // R12 six bits kept
  // R13 counts cleared by every reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rising_deadband_value <= RST_COUNT;
      falling_deadband_value <= RST_COUNT;
      falling_blanking_value <= RST_COUNT;
      rising_phase_value <= RST_COUNT;
      falling_phase_value <= RST_COUNT;
    end else if (sysReset) begin
      rising_deadband_value <= RST_COUNT;
      falling_deadband_value <= RST_COUNT;
      falling_blanking_value <= RST_COUNT;
      rising_phase_value <= RST_COUNT;
      falling_phase_value <= RST_COUNT;
    end else begin
      if (wrHit(regWr, OFS_DBR)) begin
        rising_deadband_value <= regWr.data[CNT_W-1:0];
      end
      if (wrHit(regWr, OFS_DBF)) begin
        falling_deadband_value <= regWr.data[CNT_W-1:0];
      end
      if (wrHit(regWr, OFS_BLKF)) begin
        falling_blanking_value <= regWr.data[CNT_W-1:0];
      end
      if (wrHit(regWr, OFS_PHR)) begin
        rising_phase_value <= regWr.data[CNT_W-1:0];
      end
      if (wrHit(regWr, OFS_PHF)) begin
        falling_phase_value <= regWr.data[CNT_W-1:0];
      end
    end
  end

  // R13 rising blanking survives the other reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rising_blanking_value <= RST_BLKR_POR;
    end else if (!sysReset && wrHit(regWr, OFS_BLKR)) begin
      rising_blanking_value <= regWr.data[CNT_W-1:0];
    end
  end

  // R12 upper bits read zero
  always_comb begin
    rdData = 32'h00000000;
    case (rdAddr)
      OFS_CTRL0: rdData[MODE_LSB +: 3] = generator_mode_field;
      OFS_CTRL1: begin
        rdData[RISING_DEADBAND_SOURCE_SEL_BIT] = rising_deadband_source_sel;
        rdData[FALLING_DEADBAND_SOURCE_SEL_BIT] = falling_deadband_source_sel;
        rdData[POL_LSB +: 3] = polarity;
      end
      OFS_STEER: begin
        rdData[STR_LSB +: 3] = steerEnable;
        rdData[SDAT_LSB +: 3] = staticLevel;
      end
      OFS_DBR: rdData[CNT_W-1:0] = rising_deadband_value;
      OFS_DBF: rdData[CNT_W-1:0] = falling_deadband_value;
      OFS_BLKR: rdData[CNT_W-1:0] = rising_blanking_value;
      OFS_BLKF: rdData[CNT_W-1:0] = falling_blanking_value;
      OFS_PHR: rdData[CNT_W-1:0] = rising_phase_value;
      OFS_PHF: rdData[CNT_W-1:0] = falling_phase_value;
      OFS_STATUS: rdData[4:0] = {wave, primary, complement, riseIgnored, fallIgnored};
      default: rdData = 32'h00000000;
    endcase
  end

  // delay-chain element rate
  assign chainTick = divCnt == DW'(CHAIN_DIV - 1);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt <= '0;
    end else if (chainTick) begin
      divCnt <= '0;
    end else begin
      divCnt <= divCnt + DW'(1);
    end
  end

  // R8 R9 events dropped while blanked
  assign riseAcc = riseEvent && !riseIgnored;
  assign fallAcc = fallEvent && !fallIgnored;

  // R8 blanking after rising event
  cot_delay #(.W(CNT_W)) u_blank_rise (
    .ref_clk(ref_clk), .arst_n(arst_n), .clear(sysReset), .tick(1'b1),
    .start(riseAcc), .count(rising_blanking_value), .done(), .busy(fallIgnored)
  );

  // R9 blanking after falling event
  cot_delay #(.W(CNT_W)) u_blank_fall (
    .ref_clk(ref_clk), .arst_n(arst_n), .clear(sysReset), .tick(1'b1),
    .start(fallAcc), .count(falling_blanking_value), .done(), .busy(riseIgnored)
  );

  // R10 rising phase delay
  cot_delay #(.W(CNT_W)) u_phase_rise (
    .ref_clk(ref_clk), .arst_n(arst_n), .clear(sysReset), .tick(1'b1),
    .start(riseAcc), .count(rising_phase_value), .done(riseSet), .busy()
  );

  // R11 falling phase delay
  cot_delay #(.W(CNT_W)) u_phase_fall (
    .ref_clk(ref_clk), .arst_n(arst_n), .clear(sysReset), .tick(1'b1),
    .start(fallAcc), .count(falling_phase_value), .done(fallSet), .busy()
  );

  // base waveform, rise wins a tie
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wave <= 1'b0;
    end else if (sysReset) begin
      wave <= 1'b0;
    end else if (riseSet) begin
      wave <= 1'b1;
    end else if (fallSet) begin
      wave <= 1'b0;
    end
  end

  // R4 R5 rising dead-band, clock or chain periods
  cot_delay #(.W(CNT_W)) u_db_rise (
    .ref_clk(ref_clk), .arst_n(arst_n), .clear(sysReset || (fallSet && !riseSet)),
    .tick(rising_deadband_source_sel ? chainTick : 1'b1), .start(riseSet),
    .count(rising_deadband_value), .done(dbRiseDone), .busy()
  );

  // R6 R7 falling dead-band, clock or chain periods
  cot_delay #(.W(CNT_W)) u_db_fall (
    .ref_clk(ref_clk), .arst_n(arst_n), .clear(sysReset || riseSet),
    .tick(falling_deadband_source_sel ? chainTick : 1'b1), .start(fallSet),
    .count(falling_deadband_value), .done(dbFallDone), .busy()
  );

  // primary and complementary edges, break before make
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      primary <= 1'b0;
      complement <= 1'b0;
    end else if (sysReset) begin
      primary <= 1'b0;
      complement <= 1'b0;
    end else begin
      if (fallSet && !riseSet) begin
        primary <= 1'b0;
      end else if (dbRiseDone) begin
        primary <= 1'b1;
      end
      if (riseSet) begin
        complement <= 1'b0;
      end else if (dbFallDone) begin
        complement <= 1'b1;
      end
    end
  end

  // R3 steering only in the steering modes
  assign steerOn = generator_mode_field[2:1] == STEER_MODE_HI;
  assign waveSel = {complement, primary, complement};

  // per-output steering
  generate
    for (genvar i = 0; i < 3; i++) begin : g_steer
      // R1 R2 waveform or static level
      assign next_pins[i] = (steerOn && !steerEnable[i]) ? staticLevel[i]
                                                         : waveSel[i] ^ polarity[i];
    end
  endgenerate

  // registered pins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pins <= 3'h0;
    end else begin
      pins <= next_pins;
    end
  end
  assign outB = pins[0];
  assign outC = pins[1];
  assign outD = pins[2];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n || sysReset);

  // R1 steered pin follows waveform
  property p_steer_wave;
    steerOn && steerEnable[0] |=> outB == ($past(complement) ^ $past(polarity[0]));
  endproperty
  a_steer_wave: assert property (p_steer_wave) else $error("steered pin B wrong"); // R1

  // R2 static level when unsteered
  property p_steer_static;
    steerOn && !steerEnable[1] |=> outC == $past(staticLevel[1]);
  endproperty
  a_steer_static: assert property (p_steer_static) else $error("static pin C wrong"); // R2

  // R3 steering bits ignored
  property p_no_steer;
    !steerOn |=> outD == ($past(complement) ^ $past(polarity[2]));
  endproperty
  a_no_steer: assert property (p_no_steer) else $error("pin D steered outside mode"); // R3

  // R4 rising dead-band of two clocks
  property p_db_rise;
    ($rose(wave) && !rising_deadband_source_sel && rising_deadband_value == 6'h02 && !riseSet)
      ##1 (wave && !riseSet && !fallSet) |-> !primary ##1 primary;
  endproperty
  a_db_rise: assert property (p_db_rise) else $error("rising dead-band wrong"); // R4

  // R6 falling dead-band of three clocks
  property p_db_fall;
    ($fell(wave) && !falling_deadband_source_sel && falling_deadband_value == 6'h03 && !fallSet)
      ##1 (!wave && !riseSet && !fallSet)[*2] |-> !complement ##1 complement;
  endproperty
  a_db_fall: assert property (p_db_fall) else $error("falling dead-band wrong"); // R6

  // R8 falls ignored for the blanking count
  property p_blank_rise;
    riseAcc && rising_blanking_value == 6'h04 |=> fallIgnored[*4] ##1 (!fallIgnored ||
      $past(riseAcc) || $past(riseAcc, 2) || $past(riseAcc, 3) || $past(riseAcc, 4));
  endproperty
  a_blank_rise: assert property (p_blank_rise) else $error("rising blanking wrong"); // R8

  // R9 rises ignored for the blanking count
  property p_blank_fall;
    fallAcc && falling_blanking_value == 6'h04 |=> riseIgnored[*4] ##1 (!riseIgnored ||
      $past(fallAcc) || $past(fallAcc, 2) || $past(fallAcc, 3) || $past(fallAcc, 4));
  endproperty
  a_blank_fall: assert property (p_blank_fall) else $error("falling blanking wrong"); // R9

  // R10 rising phase delay of two clocks
  property p_phase_rise;
    (riseAcc && rising_phase_value == 6'h02) ##1 (!riseAcc && !riseSet) ##1 !riseAcc
      |-> riseSet;
  endproperty
  a_phase_rise: assert property (p_phase_rise) else $error("rising phase wrong"); // R10

  // R12 count reads keep upper bits zero
  property p_upper_zero;
    rdAddr >= OFS_DBR && rdAddr <= OFS_PHF |-> rdData[31:CNT_W] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("count upper bits set"); // R12

  // R14 zero phase passes at once
  property p_zero_phase;
    fallAcc && falling_phase_value == 6'h00 |-> fallSet;
  endproperty
  a_zero_phase: assert property (p_zero_phase) else $error("zero phase delayed"); // R14
endmodule : cot_output_timing
`default_nettype wire

// file: tb/cot_switch_model.sv
// stand-in for the external gate drivers, watching the three output pins
`timescale 1ns/1ps
`default_nettype none
module cot_switch_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // gate drive pins
  input wire logic outB,
  input wire logic outC,
  input wire logic outD,
  // observation
  output logic [15:0] riseCnt,
  output logic [15:0] skewCnt
);
  logic lastC;
  // count primary switch turn-ons and cycles where the two complement legs disagree
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lastC <= 1'b0;
      riseCnt <= 16'h0;
      skewCnt <= 16'h0;
    end else begin
      lastC <= outC;
      if (outC && !lastC) riseCnt <= riseCnt + 16'h1;
      if (outB != outD) skewCnt <= skewCnt + 16'h1;
    end
  end
endmodule : cot_switch_model
`default_nettype wire

// file: tb/cot_output_timing_tb.sv
// self-checking bench for the complementary output timing block
`timescale 1ns/1ps
`default_nettype none
module cot_output_timing_tb;
  import cot_pkg::*;
  localparam int DIV = 3;
  logic refClk, arstN, sysReset, hsel, hwrite, riseEvent, fallEvent;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, pinVec;
  logic hready, hresp, outB, outC, outD;
  logic [15:0] riseCnt, skewCnt;
  int errorCnt = 0;
  int numChecks = 0;
  int expRises = 0;
  assign pinVec = {outD, outC, outB};
  cot_output_timing #(.CHAIN_DIV(DIV)) i_cot_output_timing (.ref_clk(refClk), .arst_n(arstN),
    .sysReset(sysReset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .riseEvent(riseEvent), .fallEvent(fallEvent), .outB(outB), .outC(outC),
    .outD(outD));
  cot_switch_model i_cot_switch_model (.ref_clk(refClk), .arst_n(arstN), .outB(outB),
    .outC(outC), .outD(outD), .riseCnt(riseCnt), .skewCnt(skewCnt));
  // free-running 50 MHz clock
  initial begin
    refClk = 1'b0;
    forever #10 refClk = ~refClk;
  end
  task automatic endSim();
    $display("checks=%0d errors=%0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : endSim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int got, input int lo, input int hi);
    numChecks++;
    if (got < lo || got > hi) begin
      errorCnt++;
      $display("[FAIL] t=%0t got=%h lo=%h hi=%h", $time, got, lo, hi);
    end
  endtask : chk_rng
  // one single-word transfer, waiting on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge refClk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge refClk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge refClk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
    chk(32'({hready, hresp}), 32'h2);
  endtask : rd_chk
  task automatic clean();
    @(posedge refClk);
    sysReset <= 1'b1;
    @(posedge refClk);
    sysReset <= 1'b0;
    repeat (2) @(posedge refClk);
  endtask : clean
  // one-cycle event; returns at the edge that samples it
  task automatic pulse(input logic rise);
    @(posedge refClk);
    if (rise) riseEvent <= 1'b1;
    else fallEvent <= 1'b1;
    @(posedge refClk);
    riseEvent <= 1'b0;
    fallEvent <= 1'b0;
  endtask : pulse
  // edges from the sampling edge until the chosen pin reads high
  task automatic meas(input int idx, output int n);
    n = 1;
    #1;
    while (pinVec[idx] !== 1'b1 && n < 300) begin
      @(posedge refClk);
      #1;
      n++;
    end
  endtask : meas
  task automatic t_regs();
    logic [7:0] cnts [6] = '{OFS_DBR, OFS_DBF, OFS_BLKR, OFS_BLKF, OFS_PHR, OFS_PHF};
    foreach (cnts[i]) begin
      rd_chk(cnts[i], 32'h0);
      wr(cnts[i], 32'hffffffff);
      rd_chk(cnts[i], 32'h3f);
    end
    clean();
    foreach (cnts[i]) rd_chk(cnts[i], (cnts[i] == OFS_BLKR) ? 32'h3f : 32'h0);
    wr(OFS_BLKR, 32'h0);
    rd_chk(8'h3c, 32'h0);
  endtask : t_regs
  task automatic t_timing(input int ph, input int db, input int pf, input int dbf);
    int n;
    clean();
    wr(OFS_CTRL0, 32'h2);
    wr(OFS_PHR, 32'(ph));
    wr(OFS_DBR, 32'(db));
    wr(OFS_PHF, 32'(pf));
    wr(OFS_DBF, 32'(dbf));
    pulse(1'b1);
    meas(1, n);
    chk(32'(n), 32'(ph + db + 2));
    pulse(1'b0);
    meas(0, n);
    chk(32'(n), 32'(pf + dbf + 2));
    expRises++;
  endtask : t_timing
  task automatic t_chain();
    int n;
    clean();
    wr(OFS_CTRL0, 32'h2);
    wr(OFS_CTRL1, 32'hc0);
    wr(OFS_DBR, 32'h4);
    wr(OFS_DBF, 32'h2);
    pulse(1'b1);
    meas(1, n);
    chk_rng(n, 3 * DIV + 3, 4 * DIV + 3);
    pulse(1'b0);
    meas(0, n);
    chk_rng(n, DIV + 3, 2 * DIV + 3);
    expRises++;
  endtask : t_chain
  task automatic t_blank();
    clean();
    wr(OFS_CTRL0, 32'h2);
    wr(OFS_BLKR, 32'h4);
    wr(OFS_BLKF, 32'h4);
    pulse(1'b1);
    pulse(1'b0);
    repeat (8) @(posedge refClk);
    #1 chk(32'(outC), 32'h1);
    pulse(1'b0);
    pulse(1'b1);
    repeat (8) @(posedge refClk);
    #1 chk(32'(pinVec), 32'h5);
    rd_chk(OFS_STATUS, 32'h4);
    wr(OFS_BLKR, 32'h0);
    expRises++;
  endtask : t_blank
  task automatic t_steer();
    clean();
    wr(OFS_STEER, 32'he0);
    for (int m = 0; m < 8; m++) begin
      wr(OFS_CTRL0, 32'(m));
      repeat (2) @(posedge refClk);
      #1 chk(32'(pinVec), (m < 2) ? 32'h7 : 32'h0);
    end
    wr(OFS_CTRL0, 32'h0);
    wr(OFS_STEER, 32'h0e);
    wr(OFS_CTRL1, 32'h0e);
    repeat (2) @(posedge refClk);
    #1 chk(32'(pinVec), 32'h7);
    wr(OFS_CTRL1, 32'h04);
    repeat (2) @(posedge refClk);
    #1 chk(32'(pinVec), 32'h2);
  endtask : t_steer
  // main sequence
  initial begin
    arstN = 1'b0;
    sysReset = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    riseEvent = 1'b0;
    fallEvent = 1'b0;
    repeat (6) @(posedge refClk);
    arstN <= 1'b1;
    t_regs();
    t_timing(0, 0, 0, 0);
    t_timing(2, 2, 5, 1);
    t_timing(1, 7, 0, 3);
    t_chain();
    t_blank();
    chk(32'(riseCnt), 32'(expRises));
    chk(32'(skewCnt), 32'h0);
    t_steer();
    endSim();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge refClk);
    errorCnt++;
    endSim();
  end
endmodule : cot_output_timing_tb
`default_nettype wire
